// file: rtl/flash_bus_map.svh
`ifndef FLASH_BUS_MAP_SVH
`define FLASH_BUS_MAP_SVH

// bus widths
`define ADDR_W 19
`define DATA_W 32
`define SECTOR_W 6

// sector layout: eight small, thirty big, eight small
`define SECTOR_COUNT 46
`define BIG_SECTOR_LSB 14
`define SMALL_SECTOR_LSB 11
`define LAST_BIG_BLOCK 5'h1f
`define MID_SECTOR_BASE 6'h07
`define TOP_BOOT_FIRST 6'h26

// write guard covers two outermost sectors of the chosen boot end
`define GUARD_BOTTOM_LAST 6'h01
`define GUARD_TOP_FIRST 6'h2c

// protection status read
`define PROT_LOW_BYTE 8'h02
`define PROT_PAD_W 30

// bank select field, bank 0 code
`define BANK_MSB 18
`define BANK_LSB 17
`define BANK0_CODE 2'h0

// command code that returns the latches to read-array
`define RESET_CMD_CODE 8'hf0

// reset values
`define PROT_RESET_VALUE 1'b0
`define WORD_RESET_VALUE 32'h0000_0000
`define ADDR_RESET_VALUE 19'h0_0000

`endif

// file: rtl/flash_bus_pkg.sv
`include "flash_bus_map.svh"

package flash_bus_pkg;
   // mode held by the command latches
   typedef enum logic {mode_read_array, mode_command} mode_e;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`SECTOR_W-1:0] sector_t;
endpackage

// file: rtl/sector_protect_store.sv
`timescale 1ns/100ps
`include "flash_bus_map.svh"

module sector_protect_store (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // protect bit updates from the embedded engine
   input wire logic prot_wr_valid,
   input wire flash_bus_pkg::sector_t prot_wr_sector,
   input wire logic prot_wr_persistent,
   input wire logic prot_wr_dynamic,
   // status lookup for reads
   input wire flash_bus_pkg::addr_t rd_addr,
   output logic rd_persistent,
   output logic rd_dynamic,
   // guard lookup for commands
   input wire flash_bus_pkg::addr_t wr_addr,
   input wire logic write_guard_n,
   input wire logic boot_top,
   output logic wr_blocked
);

   // sector number from a word address; used for both lookups
   function automatic flash_bus_pkg::sector_t sector_index(input flash_bus_pkg::addr_t a);
      logic [`ADDR_W-`BIG_SECTOR_LSB-1:0] blk;
      blk = a[`ADDR_W-1:`BIG_SECTOR_LSB];
      if (blk == '0)
         sector_index = {3'h0, a[`BIG_SECTOR_LSB-1:`SMALL_SECTOR_LSB]};
      else if (blk == `LAST_BIG_BLOCK)
         sector_index = `TOP_BOOT_FIRST + {3'h0, a[`BIG_SECTOR_LSB-1:`SMALL_SECTOR_LSB]};
      else
         sector_index = `MID_SECTOR_BASE + {1'b0, blk};
   endfunction

   logic [`SECTOR_COUNT-1:0] pers_reg; // persistent_protect_bit per sector
   logic [`SECTOR_COUNT-1:0] pers_next;
   logic [`SECTOR_COUNT-1:0] dyn_reg; // dynamic_protect_bit per sector
   logic [`SECTOR_COUNT-1:0] dyn_next;
   flash_bus_pkg::sector_t rd_sec;
   flash_bus_pkg::sector_t wr_sec;
   logic guard_hit;

   // per-sector update decode
   always_comb
   begin
      pers_next = pers_reg;
      dyn_next = dyn_reg;
      for (int i = 0; i < `SECTOR_COUNT; i++)
      begin
         if (prot_wr_valid && (prot_wr_sector == flash_bus_pkg::sector_t'(i)))
         begin
            pers_next[i] = prot_wr_persistent;
            dyn_next[i] = prot_wr_dynamic;
         end
      end
   end

   // bits register only
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pers_reg <= {`SECTOR_COUNT{`PROT_RESET_VALUE}};
         dyn_reg <= {`SECTOR_COUNT{`PROT_RESET_VALUE}};
      end
      else
      begin
         pers_reg <= pers_next;
         dyn_reg <= dyn_next;
      end
   end

   // lookups; out-of-range sectors cannot occur with a 19-bit address
   always_comb
   begin
      rd_sec = sector_index(rd_addr);
      wr_sec = sector_index(wr_addr);
      rd_persistent = pers_reg[rd_sec];
      rd_dynamic = dyn_reg[rd_sec];
      // guard hits the outermost pair at the selected boot end
      guard_hit = boot_top ? (wr_sec >= `GUARD_TOP_FIRST) : (wr_sec <= `GUARD_BOTTOM_LAST);
      wr_blocked = (~write_guard_n & guard_hit) | pers_reg[wr_sec] | dyn_reg[wr_sec];
   end

endmodule

// file: rtl/flash_bus_operation_decoder.sv
`timescale 1ns/100ps
`include "flash_bus_map.svh"


module flash_bus_operation_decoder (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // bus control pins
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic hw_reset_n,
   input wire logic burst_clk,
   input wire logic addr_valid_n,
   // address pins and id level flag on address line 9
   input wire flash_bus_pkg::addr_t addr,
   input wire logic high_voltage_id_level,
   // data pins
   input wire flash_bus_pkg::word_t dq_in,
   output flash_bus_pkg::word_t dq_out,
   output logic dq_oe,
   // ready-busy open drain
   output logic ready_busy_n_out,
   output logic ready_busy_n_oe,
   // protection straps
   input wire logic write_guard_n,
   input wire logic boot_top,
   // array port
   output flash_bus_pkg::addr_t array_addr,
   input wire flash_bus_pkg::word_t array_rd_data,
   // command latch output
   output logic cmd_valid,
   output flash_bus_pkg::addr_t cmd_addr,
   output flash_bus_pkg::word_t cmd_data,
   output logic cmd_sync,
   output logic cmd_blocked,
   // embedded engine
   input wire logic embedded_busy,
   input wire logic busy_bank,
   input wire flash_bus_pkg::word_t engine_status,
   // protect bit updates
   input wire logic prot_wr_valid,
   input wire flash_bus_pkg::sector_t prot_wr_sector,
   input wire logic prot_wr_persistent,
   input wire logic prot_wr_dynamic
);

   // registered state
   flash_bus_pkg::mode_e mode_reg; // command latch mode
   flash_bus_pkg::mode_e mode_next;
   logic clk_prev_reg; // last sample of burst clock
   logic clk_prev_next;
   logic burst_active_reg; // burst in progress
   logic burst_active_next;
   flash_bus_pkg::addr_t burst_addr_reg; // current burst word
   flash_bus_pkg::addr_t burst_addr_next;
   logic write_pend_reg; // write strobe was low last cycle
   logic write_pend_next;
   logic sync_seen_reg; // clock and address-valid low during write
   logic sync_seen_next;
   flash_bus_pkg::addr_t wr_addr_reg; // async write address
   flash_bus_pkg::addr_t wr_addr_next;
   flash_bus_pkg::word_t wr_data_reg; // write data sampled while strobe low
   flash_bus_pkg::word_t wr_data_next;
   logic cmd_valid_reg;
   logic cmd_valid_next;
   flash_bus_pkg::addr_t cmd_addr_reg;
   flash_bus_pkg::addr_t cmd_addr_next;
   flash_bus_pkg::word_t cmd_data_reg;
   flash_bus_pkg::word_t cmd_data_next;
   logic cmd_sync_reg;
   logic cmd_sync_next;
   logic cmd_blocked_reg;
   logic cmd_blocked_next;
   flash_bus_pkg::word_t dq_out_reg;
   flash_bus_pkg::word_t dq_out_next;
   logic dq_oe_reg;
   logic dq_oe_next;
   logic busy_reg; // drives ready-busy low
   logic busy_next;

   // decoded bus operations
   logic selected; // select low and not in hardware reset
   logic read_op;
   logic write_op;
   logic clk_rise;
   logic load_op;
   logic advance_op;
   logic write_done;
   logic prot_read;
   logic status_read;
   logic rd_bank;
   logic rd_persistent;
   logic rd_dynamic;
   logic guard_blocked;
   flash_bus_pkg::addr_t rd_addr;
   flash_bus_pkg::addr_t latch_addr;
   flash_bus_pkg::word_t read_word;

   // pin-level decode; reset low wins over every other input
   always_comb
   begin
      selected = ~chip_sel_n & hw_reset_n;
      read_op = selected & ~out_en_n & wr_en_n;
      write_op = selected & out_en_n & ~wr_en_n;
      clk_rise = burst_clk & ~clk_prev_reg;
      // load is allowed with output enable either way
      load_op = selected & wr_en_n & ~addr_valid_n & clk_rise;
      advance_op = read_op & addr_valid_n & clk_rise & burst_active_reg;
      // write completes on the rising write strobe
      write_done = write_pend_reg & selected & out_en_n & wr_en_n;
      // sync writes use the address loaded with address-valid
      latch_addr = sync_seen_reg ? burst_addr_reg : wr_addr_reg;
   end

   // read path: burst word, protect status, engine status or array
   always_comb
   begin
      rd_addr = burst_active_reg ? burst_addr_reg : addr;
      rd_bank = (rd_addr[`BANK_MSB:`BANK_LSB] != `BANK0_CODE);
      prot_read = high_voltage_id_level & (addr[7:0] == `PROT_LOW_BYTE);
      // only the busy bank shows status, the other keeps serving array data
      status_read = (embedded_busy & (rd_bank == busy_bank))
         | ((mode_reg == flash_bus_pkg::mode_command) & ~embedded_busy);
      if (prot_read)
         read_word = {{`PROT_PAD_W{1'b0}}, rd_dynamic, rd_persistent};
      else if (status_read)
         read_word = engine_status;
      else
         read_word = array_rd_data;
   end

   // burst address tracking
   always_comb
   begin
      clk_prev_next = burst_clk;
      burst_active_next = burst_active_reg;
      burst_addr_next = burst_addr_reg;
      if (!selected)
         burst_active_next = 1'b0;
      else if (load_op)
      begin
         // a load during a burst ends it and starts a new one
         burst_active_next = 1'b1;
         burst_addr_next = addr;
      end
      else if (advance_op)
         burst_addr_next = burst_addr_reg + flash_bus_pkg::addr_t'(1);
   end

   // command latches and mode
   always_comb
   begin
      mode_next = mode_reg;
      write_pend_next = write_op;
      sync_seen_next = sync_seen_reg;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;
      cmd_valid_next = 1'b0;
      cmd_addr_next = cmd_addr_reg;
      cmd_data_next = cmd_data_reg;
      cmd_sync_next = cmd_sync_reg;
      cmd_blocked_next = cmd_blocked_reg;
      if (write_op)
      begin
         // sample address and data each cycle the strobe is low
         wr_addr_next = addr;
         wr_data_next = dq_in;
         if (!write_pend_reg)
            sync_seen_next = 1'b0;
         if (!burst_clk && !addr_valid_n)
            sync_seen_next = 1'b1;
      end
      if (write_done)
      begin
         cmd_valid_next = 1'b1;
         cmd_addr_next = latch_addr;
         cmd_data_next = wr_data_reg;
         cmd_sync_next = sync_seen_reg;
         cmd_blocked_next = guard_blocked;
         // mode changes only when the latches change or on hardware reset
         if (wr_data_reg[7:0] == `RESET_CMD_CODE)
            mode_next = flash_bus_pkg::mode_read_array;
         else
            mode_next = flash_bus_pkg::mode_command;
      end
      if (!hw_reset_n)
      begin
         // hardware reset throws away any half-written command
         mode_next = flash_bus_pkg::mode_read_array;
         write_pend_next = 1'b0;
         cmd_valid_next = 1'b0;
      end
   end

   // output drive and ready-busy
   always_comb
   begin
      dq_oe_next = read_op;
      dq_out_next = read_op ? read_word : dq_out_reg;
      busy_next = embedded_busy | ~hw_reset_n;
   end

   // burst, read and ready-busy registers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         clk_prev_reg <= 1'b0;
         burst_active_reg <= 1'b0;
         burst_addr_reg <= `ADDR_RESET_VALUE;
         dq_out_reg <= `WORD_RESET_VALUE;
         dq_oe_reg <= 1'b0;
         busy_reg <= 1'b1;
      end
      else
      begin
         clk_prev_reg <= clk_prev_next;
         burst_active_reg <= burst_active_next;
         burst_addr_reg <= burst_addr_next;
         dq_out_reg <= dq_out_next;
         dq_oe_reg <= dq_oe_next;
         busy_reg <= busy_next;
      end
   end

   // command latch registers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mode_reg <= flash_bus_pkg::mode_read_array;
         write_pend_reg <= 1'b0;
         sync_seen_reg <= 1'b0;
         wr_addr_reg <= `ADDR_RESET_VALUE;
         wr_data_reg <= `WORD_RESET_VALUE;
         cmd_valid_reg <= 1'b0;
         cmd_addr_reg <= `ADDR_RESET_VALUE;
         cmd_data_reg <= `WORD_RESET_VALUE;
         cmd_sync_reg <= 1'b0;
         cmd_blocked_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         write_pend_reg <= write_pend_next;
         sync_seen_reg <= sync_seen_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
         cmd_valid_reg <= cmd_valid_next;
         cmd_addr_reg <= cmd_addr_next;
         cmd_data_reg <= cmd_data_next;
         cmd_sync_reg <= cmd_sync_next;
         cmd_blocked_reg <= cmd_blocked_next;
      end
   end

   // per-sector protect bits and write guard
   sector_protect_store u_protect (
      .core_clk(core_clk),
      .srst(srst),
      .prot_wr_valid(prot_wr_valid),
      .prot_wr_sector(prot_wr_sector),
      .prot_wr_persistent(prot_wr_persistent),
      .prot_wr_dynamic(prot_wr_dynamic),
      .rd_addr(rd_addr),
      .rd_persistent(rd_persistent),
      .rd_dynamic(rd_dynamic),
      .wr_addr(latch_addr),
      .write_guard_n(write_guard_n),
      .boot_top(boot_top),
      .wr_blocked(guard_blocked)
   );

   // outputs; open drain only ever pulls low
   assign dq_out = dq_out_reg;
   assign dq_oe = dq_oe_reg;
   assign ready_busy_n_out = 1'b0;
   assign ready_busy_n_oe = busy_reg;
   assign array_addr = rd_addr;
   assign cmd_valid = cmd_valid_reg;
   assign cmd_addr = cmd_addr_reg;
   assign cmd_data = cmd_data_reg;
   assign cmd_sync = cmd_sync_reg;
   assign cmd_blocked = cmd_blocked_reg;

endmodule

// file: tb/flash_bus_checker_assertions.sv
`timescale 1ns/100ps
module flash_bus_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // bus control pins
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic hw_reset_n,
   input wire logic burst_clk,
   input wire logic addr_valid_n,
   input wire flash_bus_pkg::addr_t addr,
   input wire logic high_voltage_id_level,
   // outputs watched
   input wire flash_bus_pkg::word_t dq_out,
   input wire logic dq_oe,
   input wire logic ready_busy_n_oe,
   input wire flash_bus_pkg::addr_t array_addr,
   input wire logic cmd_valid,
   input wire logic embedded_busy
);
   // one clock domain, so clocking and disable are set once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // plain read cycle
   sequence rd_seq;
      !chip_sel_n && !out_en_n && wr_en_n && hw_reset_n;
   endsequence
   // sampled clock rise that loads a burst start
   sequence load_seq;
      !burst_clk ##1 (burst_clk && !chip_sel_n && wr_en_n && !addr_valid_n && hw_reset_n);
   endsequence
   // strobe low then high with output disabled
   sequence strobe_seq;
      (!chip_sel_n && out_en_n && !wr_en_n && hw_reset_n)
      ##1 (!chip_sel_n && out_en_n && wr_en_n && hw_reset_n);
   endsequence
   // checked during reset itself, hence no disable
   reset_float_a: assert property (disable iff (1'b0) srst |=> !dq_oe && ready_busy_n_oe)
      else $error("outputs not idle after reset");
   hw_reset_a: assert property (!hw_reset_n |=> !dq_oe && ready_busy_n_oe)
      else $error("hardware reset left bus driven");
   read_drive_a: assert property (rd_seq |=> dq_oe)
      else $error("read cycle did not drive data");
   deselect_float_a: assert property (chip_sel_n || out_en_n |=> !dq_oe)
      else $error("data driven while not reading");
   status_word_a: assert property (rd_seq ##0 (high_voltage_id_level && addr[7:0] == 8'h02)
      |=> dq_out[31:2] == 30'h0) else $error("status read upper bits set");
   burst_load_a: assert property (load_seq |=> array_addr == $past(addr))
      else $error("burst start not captured");
   burst_step_a: assert property (load_seq ##1 (!burst_clk && !chip_sel_n && hw_reset_n)
      ##1 (burst_clk && !chip_sel_n && !out_en_n && wr_en_n && addr_valid_n && hw_reset_n)
      |=> array_addr == $past(array_addr) + 19'h1) else $error("burst did not step");
   cmd_latch_a: assert property (strobe_seq |=> cmd_valid)
      else $error("command not latched");
   cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse too long");
   cmd_cause_a: assert property (cmd_valid |-> $past(wr_en_n) && !$past(wr_en_n, 2))
      else $error("command without strobe");
   busy_follow_a: assert property (hw_reset_n ##1 hw_reset_n
      |=> ready_busy_n_oe == $past(embedded_busy)) else $error("busy pin wrong");
endmodule
bind flash_bus_operation_decoder flash_bus_checker check (.core_clk, .srst, .chip_sel_n,
   .out_en_n, .wr_en_n, .hw_reset_n, .burst_clk, .addr_valid_n, .addr, .high_voltage_id_level,
   .dq_out, .dq_oe, .ready_busy_n_oe, .array_addr, .cmd_valid, .embedded_busy);

// file: tb/array_model.sv
`timescale 1ns/100ps
module array_model (
   // array port
   input wire flash_bus_pkg::addr_t array_addr,
   output flash_bus_pkg::word_t array_rd_data
);
   // distinct word per address so a wrong address shows at once
   assign array_rd_data = {13'h0a5c, array_addr} ^ 32'h5a00_0000;
endmodule

// file: tb/flash_bus_operation_decoder_test.sv
`timescale 1ns/100ps
module flash_bus_operation_decoder_test;
   // pins driven by the bench
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic chip_sel_n = 1'b1, out_en_n = 1'b1, wr_en_n = 1'b1, hw_reset_n = 1'b1;
   logic burst_clk = 1'b0, addr_valid_n = 1'b1, high_voltage_id_level = 1'b0;
   logic write_guard_n = 1'b1, boot_top = 1'b0, embedded_busy = 1'b0, busy_bank = 1'b0;
   logic prot_wr_valid = 1'b0, prot_wr_persistent = 1'b0, prot_wr_dynamic = 1'b0;
   flash_bus_pkg::addr_t addr = 19'h1_2345;
   flash_bus_pkg::word_t dq_in = 32'h0, engine_status = 32'hc0de_0001;
   flash_bus_pkg::sector_t prot_wr_sector = 6'h00;
   // design outputs
   flash_bus_pkg::word_t dq_out, cmd_data, array_rd_data;
   flash_bus_pkg::addr_t array_addr, cmd_addr;
   logic dq_oe, ready_busy_n_out, ready_busy_n_oe, cmd_valid, cmd_sync, cmd_blocked;
   int failures = 0, n_compared = 0;

   always #12.5 core_clk = ~core_clk;

   flash_bus_operation_decoder dut (.core_clk, .srst, .chip_sel_n, .out_en_n, .wr_en_n,
      .hw_reset_n, .burst_clk, .addr_valid_n, .addr, .high_voltage_id_level, .dq_in, .dq_out,
      .dq_oe, .ready_busy_n_out, .ready_busy_n_oe, .write_guard_n, .boot_top, .array_addr,
      .array_rd_data, .cmd_valid, .cmd_addr, .cmd_data, .cmd_sync, .cmd_blocked,
      .embedded_busy, .busy_bank, .engine_status, .prot_wr_valid, .prot_wr_sector,
      .prot_wr_persistent, .prot_wr_dynamic);
   array_model partner (.array_addr, .array_rd_data);

   // expected array word, same pattern as the memory model
   function flash_bus_pkg::word_t wd(input flash_bus_pkg::addr_t a);
      return {13'h0a5c, a} ^ 32'h5a00_0000;
   endfunction

   task chk(input string n, input flash_bus_pkg::word_t s, e);
      n_compared++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one bus cycle; pins change on the edge, outputs looked at 1 ns later
   task cyc(input logic cs, oe, we, adv, bc, input flash_bus_pkg::addr_t a,
      input flash_bus_pkg::word_t d);
      @(posedge core_clk);
      chip_sel_n <= cs;
      out_en_n <= oe;
      wr_en_n <= we;
      addr_valid_n <= adv;
      burst_clk <= bc;
      addr <= a;
      dq_in <= d;
      #1;
   endtask

   // read one word, optionally at the id level
   task rd(input flash_bus_pkg::addr_t a, input flash_bus_pkg::word_t e, input logic id = 0);
      @(posedge core_clk);
      high_voltage_id_level <= id;
      cyc(0, 0, 1, 1, 0, a, 32'h0);
      cyc(0, 0, 1, 1, 0, a, 32'h0);
      chk("read enable", dq_oe, 1'b1);
      chk("read data", dq_out, e);
   endtask

   // one write, sync form holds clock and address-valid low
   task wr(input flash_bus_pkg::addr_t a, input flash_bus_pkg::word_t d, input logic sync);
      cyc(0, 1, 0, !sync, !sync, a, d);
      cyc(0, 1, 1, 1, 0, a, d);
      cyc(1, 1, 1, 1, 0, a, d);
      for (int i = 0; i < 4 && cmd_valid !== 1'b1; i++)
         @(posedge core_clk) #1;
      chk("cmd valid", cmd_valid, 1'b1);
   endtask

   task test_read;
      rd(19'h0_0004, wd(19'h0_0004));
      rd(19'h7_ffff, wd(19'h7_ffff));
      cyc(0, 1, 1, 1, 0, 19'h7_ffff, 32'h0);
      cyc(1, 0, 1, 1, 0, 19'h7_ffff, 32'h0);
      chk("output disable", dq_oe, 1'b0);
      cyc(1, 0, 1, 1, 0, 19'h7_ffff, 32'h0);
      chk("standby", dq_oe, 1'b0);
      $display("read test done");
   endtask

   task test_command;
      wr(19'h0_0555, 32'h0000_0090, 1'b0);
      chk("cmd addr", cmd_addr, 19'h0_0555);
      chk("cmd data", cmd_data, 32'h0000_0090);
      chk("cmd sync", cmd_sync, 1'b0);
      rd(19'h4_0000, engine_status);
      wr(19'h0_0aaa, 32'h0000_00f0, 1'b1);
      chk("sync write", cmd_sync, 1'b1);
      rd(19'h4_0000, wd(19'h4_0000));
      $display("command test done");
   endtask

   // guard over outermost sectors 0,1 or 44,45 only
   task automatic test_guard;
      flash_bus_pkg::addr_t ga [4] = '{19'h0_0810, 19'h7_f010, 19'h7_e810, 19'h0_0810};
      logic gt [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
      logic ge [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk);
         write_guard_n <= 1'b0;
         boot_top <= gt[i];
         wr(ga[i], 32'h0000_0090, 1'b0);
         chk("guard", cmd_blocked, ge[i]);
      end
      @(posedge core_clk);
      write_guard_n <= 1'b1;
      $display("guard test done");
   endtask

   task prot(input logic p, d);
      @(posedge core_clk);
      prot_wr_valid <= 1'b1;
      prot_wr_persistent <= p;
      prot_wr_dynamic <= d;
      @(posedge core_clk);
      prot_wr_valid <= 1'b0;
   endtask

   task test_protect;
      prot(1'b1, 1'b0);
      rd(19'h0_0002, 32'h0000_0001, 1'b1);
      // a command aimed at a protected sector is flagged even with the guard off
      wr(19'h0_0010, 32'h0000_0090, 1'b0);
      chk("protect block", cmd_blocked, 1'b1);
      prot(1'b0, 1'b1);
      rd(19'h0_0002, 32'h0000_0002, 1'b1);
      rd(19'h0_0802, 32'h0000_0000, 1'b1);
      prot(1'b0, 1'b0);
      $display("protect test done");
   endtask

   // hardware reset mid read while in command mode
   task test_hwreset;
      rd(19'h1_0000, engine_status);
      @(posedge core_clk);
      hw_reset_n <= 1'b0;
      repeat (3)
      begin
         @(posedge core_clk) #1;
         chk("float in reset", dq_oe, 1'b0);
         chk("busy in reset", ready_busy_n_oe, 1'b1);
         chk("busy pin level", ready_busy_n_out, 1'b0);
      end
      @(posedge core_clk);
      hw_reset_n <= 1'b1;
      rd(19'h1_0000, wd(19'h1_0000));
      chk("ready", ready_busy_n_oe, 1'b0);
      $display("hardware reset test done");
   endtask

   // erase busy in small bank 0, code read from bank 1
   task test_bank;
      @(posedge core_clk);
      embedded_busy <= 1'b1;
      busy_bank <= 1'b0;
      rd(19'h2_0000, wd(19'h2_0000));
      rd(19'h0_0100, engine_status);
      chk("busy pin", ready_busy_n_oe, 1'b1);
      // engine moves to bank 1: bank 0 serves array data, bank 1 shows status
      @(posedge core_clk);
      busy_bank <= 1'b1;
      rd(19'h0_0100, wd(19'h0_0100));
      rd(19'h6_0000, engine_status);
      @(posedge core_clk);
      embedded_busy <= 1'b0;
      $display("bank test done");
   endtask

   // load near the top, step across the wrap, restart, deselect
   task test_burst;
      cyc(0, 0, 1, 0, 0, 19'h7_fffe, 32'h0);
      cyc(0, 0, 1, 0, 1, 19'h7_fffe, 32'h0);
      cyc(0, 0, 1, 1, 0, 19'h1_2345, 32'h0);
      cyc(0, 0, 1, 1, 1, 19'h1_2345, 32'h0);
      chk("burst first", dq_out, wd(19'h7_fffe));
      for (int i = 1; i < 3; i++)
      begin
         cyc(0, 0, 1, 1, 0, 19'h1_2345, 32'h0);
         cyc(0, 0, 1, 1, 1, 19'h1_2345, 32'h0);
         chk("burst step", dq_out, wd(19'h7_fffe + i[18:0]));
      end
      cyc(0, 1, 1, 0, 0, 19'h0_3000, 32'h0);
      cyc(0, 1, 1, 0, 1, 19'h0_3000, 32'h0);
      cyc(0, 0, 1, 1, 0, 19'h1_2345, 32'h0);
      cyc(0, 0, 1, 1, 0, 19'h1_2345, 32'h0);
      chk("burst restart", dq_out, wd(19'h0_3000));
      cyc(1, 0, 1, 1, 0, 19'h1_2345, 32'h0);
      rd(19'h1_2345, wd(19'h1_2345));
      // sync write takes the address last loaded with address-valid
      wr(19'h0_0aaa, 32'h0000_00f0, 1'b1);
      chk("sync addr", cmd_addr, 19'h0_3000);
      $display("burst test done");
   endtask

   initial
   begin
      repeat (15) @(posedge core_clk);
      #1;
      chk("oe in reset", dq_oe, 1'b0);
      chk("busy in reset", ready_busy_n_oe, 1'b1);
      @(posedge core_clk);
      srst <= 1'b0;
      test_read;
      test_command;
      test_guard;
      test_protect;
      test_hwreset;
      test_bank;
      test_burst;
      complete_run;
   end

   // watchdog, far beyond the roughly 120 cycles the tests take
   initial
   begin
      repeat (3000) @(posedge core_clk);
      failures++;
      complete_run;
   end
endmodule
